// ==== hdl/acr_chan_cfg.sv ====
`timescale 1ns/10ps
// Per-output configuration storage; three instances per data channel, one per clock output
module acr_chan_cfg
	import acr_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	input  wire logic       sel_i,
	input  wire logic       we_i,
	input  wire logic [7:0] wmask_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic [7:0] rst_val_i,
	output logic      [7:0] cfg_o
);
	logic [7:0] cfg_q;
	logic [7:0] cfg_d;

	// Flops hold the difference from rst_val_i, so the async reset stays a constant
	assign cfg_d = ((wdata_i ^ rst_val_i) & wmask_i) | (cfg_q & ~wmask_i);
	assign cfg_o = cfg_q ^ rst_val_i;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_q <= ACR_RST_ZERO;
		end else if (ce_i && we_i && sel_i) begin
			cfg_q <= cfg_d;
		end
	end
endmodule

// ==== hdl/acr_pkg.sv ====
package acr_pkg;
	// ----------------------------------------
	// Register offsets (full serial address)
	// ----------------------------------------
	localparam logic [12:0] ACR_OFF_CHAN_LO   = 13'h004;
	localparam logic [12:0] ACR_OFF_CHAN_HI   = 13'h005;
	localparam logic [12:0] ACR_OFF_POWER     = 13'h008;
	localparam logic [12:0] ACR_OFF_ENHANCE   = 13'h00c;
	localparam logic [12:0] ACR_OFF_DIVIDER   = 13'h00b;
	localparam logic [12:0] ACR_OFF_OUT_MODE  = 13'h014;
	localparam logic [12:0] ACR_OFF_OUT_ADJ   = 13'h015;
	localparam logic [12:0] ACR_OFF_PHASE     = 13'h016;
	localparam logic [12:0] ACR_OFF_COMMIT    = 13'h0ff;
	localparam logic [12:0] ACR_OFF_OVERRIDE  = 13'h100;

	// ----------------------------------------
	// Writable bit masks (open bits read zero)
	// ----------------------------------------
	localparam logic [7:0] ACR_MASK_CHAN_LO  = 8'h0f;
	localparam logic [7:0] ACR_MASK_CHAN_HI  = 8'h3f;
	localparam logic [7:0] ACR_MASK_POWER    = 8'h23;
	localparam logic [7:0] ACR_MASK_ENHANCE  = 8'h04;
	localparam logic [7:0] ACR_MASK_DIVIDER  = 8'h07;
	localparam logic [7:0] ACR_MASK_OUT_MODE = 8'h45;
	localparam logic [7:0] ACR_MASK_OUT_ADJ  = 8'h31;
	localparam logic [7:0] ACR_MASK_PHASE    = 8'h7f;
	localparam logic [7:0] ACR_MASK_OVERRIDE = 8'h77;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] ACR_RST_CHAN_LO  = 8'h0f;
	localparam logic [7:0] ACR_RST_CHAN_HI  = 8'h3f;
	localparam logic [7:0] ACR_RST_ZERO     = 8'h00;
	localparam logic [7:0] ACR_RST_OUT_MODE = 8'h01;
	localparam logic [7:0] ACR_RST_PHASE    = 8'h03;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ACR_BIT_PIN_STBY   = 5;
	localparam int ACR_BIT_CHOP       = 2;
	localparam int ACR_BIT_LVDS_RED   = 6;
	localparam int ACR_BIT_INVERT     = 2;
	localparam int ACR_BIT_TWOS       = 0;
	localparam int ACR_BIT_DRIVE2X    = 0;
	localparam int ACR_BIT_COMMIT     = 0;
	localparam int ACR_BIT_DCO_SEL    = 5;
	localparam int ACR_BIT_FCO_SEL    = 4;
	localparam int ACR_CHANNELS       = 8;

	typedef enum logic [1:0] {
		ACR_PD_NORMAL,
		ACR_PD_POWERDOWN,
		ACR_PD_STANDBY,
		ACR_PD_RESET
	} acr_pd_type;
endpackage

// ==== hdl/acr_regs.sv ====
// Operation
// - Low four bits of both index registers select channels for per-channel writes
// - Second index register also selects data and frame clock outputs, reduced features
// - All registers but the override register take effect on write
// - Writing one to commit bit 0 applies staged override contents
// - Power bit 5 set: sleep pin gives standby; clear: full power-down
// - Power code 00 keeps all channels active
// - Code 01 gates datapath clocks, holds datapath reset, disables outputs
// - Code 10 disables datapath clocks and outputs without reset
// - Code 11 holds datapath reset with clocks running, disables outputs, not the serial port
// - Serial port never reset by power modes, only power-on reset
// - Enhancement bit 2 enables first-stage chopping
// - Output mode bit 6 selects reduced-range LVDS, default ANSI
// - Output mode bit 2 inverts serial output stream
// - Output mode bit 0 defaults one for two's complement, clear gives offset binary
// - Output adjust bits 5:4 select termination resistor
// - Output adjust bit 0 doubles drive only for selected clock outputs
// - Termination selection overrides double drive on clock outputs
// - Phase bits 6:4 delay sampling 0 to 7 input clock cycles
// - Phase bits 3:0 shift data clock in 60-degree steps, default 180
`timescale 1ns/10ps
module acr_regs
	import acr_pkg::*;
#(
	parameter int NCHAN = ACR_CHANNELS
) (
	input  wire logic                    mclk_i,
	input  wire logic                    rst_i,
	input  wire logic                    ce_i,
	input  wire logic                    wr_i,
	input  wire logic                    rd_i,
	input  wire logic [12:0]             addr_i,
	input  wire logic [7:0]              wdata_i,
	input  wire logic                    external_sleep_pin_i,
	output logic      [7:0]              rdata_o,
	output logic                         rvalid_o,
	output logic                         dp_clk_en_o,
	output logic                         dp_reset_o,
	output logic                         out_en_o,
	output logic                         standby_o,
	output logic                         powerdown_o,
	output logic      [NCHAN-1:0]        chop_en_o,
	output logic      [NCHAN-1:0]        lvds_reduced_o,
	output logic      [NCHAN-1:0]        invert_o,
	output logic      [NCHAN-1:0]        twos_comp_o,
	output logic      [2*NCHAN-1:0]      term_sel_o,
	output logic      [1:0]              clk_term_sel_o,
	output logic                         data_clock_output_drive2x_o,
	output logic                         frame_clock_output_drive2x_o,
	output logic      [2:0]              sample_delay_o,
	output logic      [3:0]              data_clock_output_phase_o,
	output logic      [7:0]              override_o
);
	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	logic sleep_s1_q;
	logic sleep_s2_q;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sleep_s1_q <= 1'b0;
			sleep_s2_q <= 1'b0;
		end else if (ce_i) begin
			sleep_s1_q <= external_sleep_pin_i;
			sleep_s2_q <= sleep_s1_q;
		end
	end

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic logic hit(input logic [12:0] a, input logic [12:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] m);
		merge = (nw & m) | (old & ~m);
	endfunction

	wire w_en          = ce_i & wr_i;
	wire hit_chan_lo   = hit(addr_i, ACR_OFF_CHAN_LO);
	wire hit_chan_hi   = hit(addr_i, ACR_OFF_CHAN_HI);
	wire hit_power     = hit(addr_i, ACR_OFF_POWER);
	wire hit_divider   = hit(addr_i, ACR_OFF_DIVIDER);
	wire hit_enhance   = hit(addr_i, ACR_OFF_ENHANCE);
	wire hit_out_mode  = hit(addr_i, ACR_OFF_OUT_MODE);
	wire hit_out_adj   = hit(addr_i, ACR_OFF_OUT_ADJ);
	wire hit_phase     = hit(addr_i, ACR_OFF_PHASE);
	wire hit_commit    = hit(addr_i, ACR_OFF_COMMIT);
	wire hit_override  = hit(addr_i, ACR_OFF_OVERRIDE);

	// ----------------------------------------
	// Global registers (serial port state, power-on reset only)
	// ----------------------------------------
	logic [7:0] chan_lo_q;
	logic [7:0] chan_hi_q;
	logic [7:0] power_q;
	logic [7:0] divider_q;
	logic [7:0] phase_q;
	logic [7:0] stage_q;
	logic [7:0] override_q;

	// Only rst_i touches these; no power mode reaches them
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			chan_lo_q  <= ACR_RST_CHAN_LO;
			chan_hi_q  <= ACR_RST_CHAN_HI;
			power_q    <= ACR_RST_ZERO;
			divider_q  <= ACR_RST_ZERO;
			phase_q    <= ACR_RST_PHASE;
			stage_q    <= ACR_RST_ZERO;
			override_q <= ACR_RST_ZERO;
		end else if (w_en) begin
			if (hit_chan_lo)
				chan_lo_q <= merge(chan_lo_q, wdata_i, ACR_MASK_CHAN_LO);
			if (hit_chan_hi)
				chan_hi_q <= merge(chan_hi_q, wdata_i, ACR_MASK_CHAN_HI);
			if (hit_power)
				power_q <= merge(power_q, wdata_i, ACR_MASK_POWER);
			if (hit_divider)
				divider_q <= merge(divider_q, wdata_i, ACR_MASK_DIVIDER);
			if (hit_phase)
				phase_q <= merge(phase_q, wdata_i, ACR_MASK_PHASE);
			if (hit_override)
				stage_q <= merge(stage_q, wdata_i, ACR_MASK_OVERRIDE);
			if (hit_commit && wdata_i[ACR_BIT_COMMIT])
				override_q <= stage_q;
		end
	end

	// ----------------------------------------
	// Per-channel registers
	// ----------------------------------------
	// Channel n < 4 chosen by low index, n >= 4 by second index low nibble
	logic [NCHAN-1:0] chan_sel;
	always_comb begin
		for (int i = 0; i < NCHAN; i++)
			chan_sel[i] = (i < 4) ? chan_lo_q[i % 4] : chan_hi_q[i % 4];
	end
	wire dco_sel = chan_hi_q[ACR_BIT_DCO_SEL];
	wire fco_sel = chan_hi_q[ACR_BIT_FCO_SEL];

	logic [7:0] enh_cfg  [NCHAN];
	logic [7:0] mode_cfg [NCHAN];
	logic [7:0] adj_cfg  [NCHAN];
	logic [7:0] dco_adj;
	logic [7:0] fco_adj;

	genvar g;
	generate
		for (g = 0; g < NCHAN; g++) begin : g_chan
			acr_chan_cfg u_enh (
				.mclk_i    (mclk_i),
				.rst_i     (rst_i),
				.ce_i      (ce_i),
				.sel_i     (chan_sel[g]),
				.we_i      (wr_i & hit_enhance),
				.wmask_i   (ACR_MASK_ENHANCE),
				.wdata_i   (wdata_i),
				.rst_val_i (ACR_RST_ZERO),
				.cfg_o     (enh_cfg[g])
			);
			// Twos default carried by rst_val_i; flops still reset to zero
			acr_chan_cfg u_mode (
				.mclk_i    (mclk_i),
				.rst_i     (rst_i),
				.ce_i      (ce_i),
				.sel_i     (chan_sel[g]),
				.we_i      (wr_i & hit_out_mode),
				.wmask_i   (ACR_MASK_OUT_MODE),
				.wdata_i   (wdata_i),
				.rst_val_i (ACR_RST_OUT_MODE),
				.cfg_o     (mode_cfg[g])
			);
			acr_chan_cfg u_adj (
				.mclk_i    (mclk_i),
				.rst_i     (rst_i),
				.ce_i      (ce_i),
				.sel_i     (chan_sel[g]),
				.we_i      (wr_i & hit_out_adj),
				.wmask_i   (ACR_MASK_OUT_ADJ & 8'h30),
				.wdata_i   (wdata_i),
				.rst_val_i (ACR_RST_ZERO),
				.cfg_o     (adj_cfg[g])
			);
		end
	endgenerate

	acr_chan_cfg u_dco_adj (
		.mclk_i    (mclk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.sel_i     (dco_sel),
		.we_i      (wr_i & hit_out_adj),
		.wmask_i   (ACR_MASK_OUT_ADJ),
		.wdata_i   (wdata_i),
		.rst_val_i (ACR_RST_ZERO),
		.cfg_o     (dco_adj)
	);
	acr_chan_cfg u_fco_adj (
		.mclk_i    (mclk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.sel_i     (fco_sel),
		.we_i      (wr_i & hit_out_adj),
		.wmask_i   (ACR_MASK_OUT_ADJ),
		.wdata_i   (wdata_i),
		.rst_val_i (ACR_RST_ZERO),
		.cfg_o     (fco_adj)
	);

	// Lowest selected channel answers reads of per-channel registers
	logic [7:0] enh_rd;
	logic [7:0] mode_rd;
	logic [7:0] adj_rd;
	always_comb begin
		enh_rd  = 8'h00;
		mode_rd = 8'h00;
		adj_rd  = 8'h00;
		for (int i = NCHAN - 1; i >= 0; i--) begin
			if (chan_sel[i]) begin
				enh_rd  = enh_cfg[i];
				mode_rd = mode_cfg[i];
				adj_rd  = adj_cfg[i];
			end
		end
		if (!(|chan_sel) && dco_sel)
			adj_rd = dco_adj;
	end

	// ----------------------------------------
	// Power mode decode
	// ----------------------------------------
	acr_pd_type pd_mode;
	assign pd_mode = acr_pd_type'(power_q[1:0]);
	wire pin_stby  = sleep_s2_q & power_q[ACR_BIT_PIN_STBY];
	wire pin_external_sleep_pin  = sleep_s2_q & ~power_q[ACR_BIT_PIN_STBY];

	logic clk_en_d;
	logic dp_rst_d;
	logic out_en_d;
	always_comb begin
		clk_en_d = 1'b1;
		dp_rst_d = 1'b0;
		out_en_d = 1'b1;
		case (pd_mode)
			ACR_PD_NORMAL: begin
				clk_en_d = 1'b1;
			end
			ACR_PD_POWERDOWN: begin
				clk_en_d = 1'b0;
				dp_rst_d = 1'b1;
				out_en_d = 1'b0;
			end
			ACR_PD_STANDBY: begin
				clk_en_d = 1'b0;
				out_en_d = 1'b0;
			end
			ACR_PD_RESET: begin
				dp_rst_d = 1'b1;
				out_en_d = 1'b0;
			end
			default: begin
				clk_en_d = 1'b1;
			end
		endcase
		if (pin_stby || pin_external_sleep_pin) begin
			clk_en_d = 1'b0;
			out_en_d = 1'b0;
		end
		if (pin_external_sleep_pin)
			dp_rst_d = 1'b1;
	end

	// ----------------------------------------
	// Readback
	// ----------------------------------------
	logic [7:0] rdata_d;
	always_comb begin
		if (hit_chan_lo)
			rdata_d = chan_lo_q;
		else if (hit_chan_hi)
			rdata_d = chan_hi_q;
		else if (hit_power)
			rdata_d = power_q;
		else if (hit_divider)
			rdata_d = divider_q;
		else if (hit_enhance)
			rdata_d = enh_rd;
		else if (hit_out_mode)
			rdata_d = mode_rd;
		else if (hit_out_adj)
			rdata_d = adj_rd;
		else if (hit_phase)
			rdata_d = phase_q;
		else if (hit_override)
			rdata_d = stage_q;
		else
			rdata_d = 8'h00;
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	logic [NCHAN-1:0]   chop_d;
	logic [NCHAN-1:0]   lvds_d;
	logic [NCHAN-1:0]   inv_d;
	logic [NCHAN-1:0]   twos_d;
	logic [2*NCHAN-1:0] term_d;
	always_comb begin
		for (int i = 0; i < NCHAN; i++) begin
			chop_d[i]       = enh_cfg[i][ACR_BIT_CHOP];
			lvds_d[i]       = mode_cfg[i][ACR_BIT_LVDS_RED];
			inv_d[i]        = mode_cfg[i][ACR_BIT_INVERT];
			twos_d[i]       = mode_cfg[i][ACR_BIT_TWOS];
			term_d[2*i +: 2] = adj_cfg[i][5:4];
		end
	end
	wire [1:0] clk_term   = dco_adj[5:4] | fco_adj[5:4];
	// Termination beats double drive on the clock outputs
	wire dco_drv_d = dco_adj[ACR_BIT_DRIVE2X] & (dco_adj[5:4] == 2'b00);
	wire fco_drv_d = fco_adj[ACR_BIT_DRIVE2X] & (fco_adj[5:4] == 2'b00);

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o                      <= 8'h00;
			rvalid_o                     <= 1'b0;
			dp_clk_en_o                  <= 1'b1;
			dp_reset_o                   <= 1'b0;
			out_en_o                     <= 1'b1;
			standby_o                    <= 1'b0;
			powerdown_o                  <= 1'b0;
			chop_en_o                    <= '0;
			lvds_reduced_o               <= '0;
			invert_o                     <= '0;
			twos_comp_o                  <= '1;
			term_sel_o                   <= '0;
			clk_term_sel_o               <= 2'b00;
			data_clock_output_drive2x_o  <= 1'b0;
			frame_clock_output_drive2x_o <= 1'b0;
			sample_delay_o               <= 3'h0;
			data_clock_output_phase_o    <= ACR_RST_PHASE[3:0];
			override_o                   <= 8'h00;
		end else if (ce_i) begin
			rdata_o                      <= rd_i ? rdata_d : rdata_o;
			rvalid_o                     <= rd_i;
			dp_clk_en_o                  <= clk_en_d;
			dp_reset_o                   <= dp_rst_d;
			out_en_o                     <= out_en_d;
			standby_o                    <= pin_stby | (pd_mode == ACR_PD_STANDBY);
			powerdown_o                  <= pin_external_sleep_pin | (pd_mode == ACR_PD_POWERDOWN);
			chop_en_o                    <= chop_d;
			lvds_reduced_o               <= lvds_d;
			invert_o                     <= inv_d;
			twos_comp_o                  <= twos_d;
			term_sel_o                   <= term_d;
			clk_term_sel_o               <= clk_term;
			data_clock_output_drive2x_o  <= dco_drv_d;
			frame_clock_output_drive2x_o <= fco_drv_d;
			// Phase beyond divider ratio is the host's fault; passed through as is
			sample_delay_o               <= phase_q[6:4];
			data_clock_output_phase_o    <= phase_q[3:0];
			override_o                   <= override_q;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_commit_apply: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && wr_i && hit_commit && wdata_i[0] |=> override_q == $past(stage_q))
		else $error("commit did not apply staged override");
	chk_stage_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && wr_i && hit_override && !$past(rst_i) |=> $stable(override_q))
		else $error("override changed without commit");
	chk_pd_reset: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && power_q[1:0] == 2'b01 |=> !dp_clk_en_o && dp_reset_o && !out_en_o)
		else $error("power-down code not applied");
	chk_stby_noreset: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && power_q[1:0] == 2'b10 && !sleep_s2_q |=> !dp_clk_en_o && !dp_reset_o)
		else $error("standby code wrong");
	chk_normal_run: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && power_q[1:0] == 2'b00 && !sleep_s2_q |=> dp_clk_en_o && out_en_o)
		else $error("normal mode not active");
	chk_dreset_port: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && power_q[1:0] == 2'b11 && !(wr_i && hit_chan_lo)
		|=> dp_reset_o && $stable(chan_lo_q))
		else $error("digital reset wrong");
	chk_pin_mode: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && sleep_s2_q && power_q[1:0] == 2'b00
		|=> standby_o == $past(power_q[5]) && powerdown_o != $past(power_q[5]))
		else $error("sleep pin mode wrong");
	chk_drive_term: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && dco_adj[5:4] != 2'b00 |=> !data_clock_output_drive2x_o)
		else $error("double drive with termination");
	chk_open_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
		(power_q & ~ACR_MASK_POWER) == 8'h00 && (phase_q & ~ACR_MASK_PHASE) == 8'h00)
		else $error("open bit set");
endmodule

// ==== verification/acr_host.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Serial host model: one register access per call
// ----------------------------------------
module acr_host
	import acr_pkg::*;
(
	input  wire logic        mclk_i,
	output logic             wr_o,
	output logic             rd_o,
	output logic      [12:0] addr_o,
	output logic      [7:0]  wdata_o
);
	logic [2:0] div_q;

	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 13'h1fff;
		wdata_o = 8'h00;
		div_q = 3'h0;
	end

	// Released lines show the inverse so stale values never match by chance
	task automatic release_bus(input logic [12:0] a, input logic [7:0] d);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask

	task automatic write_reg(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == ACR_OFF_DIVIDER) begin
			div_q = d[2:0];
		end
		// Sampling phase is never asked beyond the divider ratio
		if (a == ACR_OFF_PHASE && v[6:4] > div_q) begin
			v[6:4] = div_q;
		end
		@(posedge mclk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= v;
		@(posedge mclk_i);
		release_bus(a, v);
	endtask

	task automatic read_reg(input logic [12:0] a);
		@(posedge mclk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge mclk_i);
		release_bus(a, 8'h00);
	endtask
endmodule

// ==== verification/test_adc_control_register_bank.sv ====
`timescale 1ns/10ps
module test_adc_control_register_bank
	import acr_pkg::*;
;
	logic        mclk_i;
	logic        rst_i;
	logic        ce_i;
	logic        sleep_i;
	logic        h_wr;
	logic        h_rd;
	logic [12:0] h_addr;
	logic [7:0]  h_wdata;
	logic [7:0]  rdata_o;
	logic        rvalid_o;
	logic        dp_clk_en_o;
	logic        dp_reset_o;
	logic        out_en_o;
	logic        standby_o;
	logic        powerdown_o;
	logic [7:0]  chop_en_o;
	logic [7:0]  lvds_reduced_o;
	logic [7:0]  invert_o;
	logic [7:0]  twos_comp_o;
	logic [15:0] term_sel_o;
	logic [1:0]  clk_term_sel_o;
	logic        dco_2x;
	logic        fco_2x;
	logic [2:0]  sample_delay_o;
	logic [3:0]  dco_phase;
	logic [7:0]  override_o;
	int          error_cnt;
	int          n_checks;
	int          cyc;
	logic [7:0]  exp_q[$];
	logic [7:0]  d;
	logic [7:0]  v [10];
	logic [2:0]  pm_t [4] = '{3'b101, 3'b010, 3'b000, 3'b110};
	logic [12:0] addr_t [10] = '{ACR_OFF_POWER, ACR_OFF_ENHANCE, ACR_OFF_OUT_MODE,
		ACR_OFF_OUT_ADJ, ACR_OFF_DIVIDER, ACR_OFF_PHASE, ACR_OFF_OVERRIDE,
		ACR_OFF_CHAN_LO, ACR_OFF_CHAN_HI, 13'h030};
	// Data channels keep only termination; drive bit lives in the clock outputs
	logic [7:0]  mask_t [10] = '{ACR_MASK_POWER, ACR_MASK_ENHANCE, ACR_MASK_OUT_MODE,
		ACR_MASK_OUT_ADJ & 8'h30, ACR_MASK_DIVIDER, ACR_MASK_PHASE, ACR_MASK_OVERRIDE,
		ACR_MASK_CHAN_LO, ACR_MASK_CHAN_HI, 8'h00};
	logic [7:0]  rst_t [10] = '{ACR_RST_ZERO, ACR_RST_ZERO, ACR_RST_OUT_MODE, ACR_RST_ZERO,
		ACR_RST_ZERO, ACR_RST_PHASE, ACR_RST_ZERO, ACR_RST_CHAN_LO, ACR_RST_CHAN_HI, 8'h00};

	acr_host host (.mclk_i(mclk_i), .wr_o(h_wr), .rd_o(h_rd), .addr_o(h_addr), .wdata_o(h_wdata));

	acr_regs dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .wr_i(h_wr), .rd_i(h_rd),
		.addr_i(h_addr), .wdata_i(h_wdata), .external_sleep_pin_i(sleep_i),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o), .dp_clk_en_o(dp_clk_en_o),
		.dp_reset_o(dp_reset_o), .out_en_o(out_en_o), .standby_o(standby_o),
		.powerdown_o(powerdown_o), .chop_en_o(chop_en_o), .lvds_reduced_o(lvds_reduced_o),
		.invert_o(invert_o), .twos_comp_o(twos_comp_o), .term_sel_o(term_sel_o),
		.clk_term_sel_o(clk_term_sel_o), .data_clock_output_drive2x_o(dco_2x),
		.frame_clock_output_drive2x_o(fco_2x), .sample_delay_o(sample_delay_o),
		.data_clock_output_phase_o(dco_phase), .override_o(override_o));

	// ----------------------------------------
	// Checking and reporting
	// ----------------------------------------
	task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", name, e, g);
		end
	endtask

	task automatic print_verdict;
		$display("checks made %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [12:0] a, input logic [7:0] dv);
		host.write_reg(a, dv);
	endtask

	task automatic rd_reg(input logic [12:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.read_reg(a);
	endtask

	// Outputs follow one cycle after the write edge
	task automatic settle;
		repeat (3) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask

	always @(posedge mclk_i) begin
		if (rvalid_o === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("unrequested read", 16'h0000, {15'h0000, rvalid_o});
			end else begin
				check("read data", {8'h00, exp_q.pop_front()}, {8'h00, rdata_o});
			end
		end
	end

	// Hang guard; the whole run needs well under a thousand cycles
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			$display("unexpected cycle count: expected below 5000, seen %0d", cyc);
			print_verdict;
		end
	end

	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		sleep_i = 1'b0;
		error_cnt = 0;
		n_checks = 0;
		cyc = 0;
		void'($urandom(32'hf028f4bc));
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(negedge mclk_i);
		check("twos comp", 16'h00ff, {8'h00, twos_comp_o});
		check("dco phase", 16'h0003, {12'h000, dco_phase});
		check("lvds reduced", 16'h0000, {8'h00, lvds_reduced_o});
		check("power outs", 16'h0005, {13'h0, dp_clk_en_o, dp_reset_o, out_en_o});
		for (int i = 0; i < 10; i++) begin
			rd_reg(addr_t[i], rst_t[i]);
		end
		// Random contents; divider before phase at full ratio, selection kept non-empty
		for (int i = 0; i < 10; i++) begin
			d = 8'($urandom());
			if (i == 4) d[2:0] = 3'h7;
			if (i == 7) d[0] = 1'b1;
			v[i] = d & mask_t[i];
			wr_reg(addr_t[i], d);
			rd_reg(addr_t[i], v[i]);
		end
		settle;
		check("sample delay", {13'h0, v[5][6:4]}, {13'h0, sample_delay_o});
		check("dco phase", {12'h0, v[5][3:0]}, {12'h0, dco_phase});
		check("override staged", 16'h0000, {8'h00, override_o});
		wr_reg(ACR_OFF_COMMIT, 8'h01);
		settle;
		check("override", {8'h00, v[6]}, {8'h00, override_o});
		wr_reg(ACR_OFF_CHAN_LO, 8'h0f);
		wr_reg(ACR_OFF_CHAN_HI, 8'h3f);
		for (int c = 0; c < 4; c++) begin
			wr_reg(ACR_OFF_POWER, 8'(c));
			settle;
			check("power outs", {13'h0, pm_t[c]}, {13'h0, dp_clk_en_o, dp_reset_o, out_en_o});
			rd_reg(ACR_OFF_POWER, 8'(c));
		end
		for (int s = 0; s < 2; s++) begin
			wr_reg(ACR_OFF_POWER, (s == 1) ? 8'h20 : 8'h00);
			@(posedge mclk_i);
			sleep_i <= 1'b1;
			repeat (5) @(posedge mclk_i);
			@(negedge mclk_i);
			check("sleep pin", (s == 1) ? 16'h2 : 16'h1, {14'h0, standby_o, powerdown_o});
			@(posedge mclk_i);
			sleep_i <= 1'b0;
			repeat (5) @(posedge mclk_i);
		end
		// After an all-channel mode write, per-channel writes reach only channels 2 and 5
		wr_reg(ACR_OFF_OUT_MODE, 8'h01);
		wr_reg(ACR_OFF_CHAN_LO, 8'h04);
		wr_reg(ACR_OFF_CHAN_HI, 8'h02);
		wr_reg(ACR_OFF_OUT_MODE, 8'h04);
		wr_reg(ACR_OFF_ENHANCE, 8'hff);
		settle;
		check("chop", {8'h00, ({8{v[1][2]}} | 8'h24)}, {8'h00, chop_en_o});
		rd_reg(ACR_OFF_ENHANCE, 8'h04);
		check("invert", 16'h0024, {8'h00, invert_o});
		check("twos comp", 16'h00db, {8'h00, twos_comp_o});
		rd_reg(ACR_OFF_OUT_MODE, 8'h04);
		wr_reg(ACR_OFF_OUT_MODE, 8'h40);
		settle;
		check("lvds reduced", 16'h0024, {8'h00, lvds_reduced_o});
		// Clock outputs only
		wr_reg(ACR_OFF_CHAN_LO, 8'h00);
		wr_reg(ACR_OFF_CHAN_HI, 8'h30);
		wr_reg(ACR_OFF_OUT_ADJ, 8'h00);
		wr_reg(ACR_OFF_CHAN_HI, 8'h20);
		wr_reg(ACR_OFF_OUT_ADJ, 8'h01);
		settle;
		check("drive2x", 16'h0002, {14'h0, dco_2x, fco_2x});
		check("data term", {8{v[3][5:4]}}, term_sel_o);
		wr_reg(ACR_OFF_CHAN_HI, 8'h30);
		wr_reg(ACR_OFF_OUT_ADJ, 8'h11);
		settle;
		check("drive2x", 16'h0000, {14'h0, dco_2x, fco_2x});
		check("clock term", 16'h0001, {14'h0, clk_term_sel_o});
		// Clock enable low must freeze the write
		@(posedge mclk_i);
		ce_i <= 1'b0;
		wr_reg(ACR_OFF_PHASE, 8'h00);
		@(posedge mclk_i);
		ce_i <= 1'b1;
		rd_reg(ACR_OFF_PHASE, v[5]);
		repeat (4) @(posedge mclk_i);
		check("pending reads", 16'h0000, 16'(exp_q.size()));
		print_verdict;
	end
endmodule
